/* rtl/tsc_pkg.sv */
// Constants, types and timing for the touch grid auto scanner.
// Assumes a single 200 MHz system clock and a passive 16 x 8 contact grid.
package tsc_pkg;
  localparam int NUM_COLUMNS = 16;
  localparam int NUM_ROWS = 8;
  localparam int COL_W = 4;
  localparam int ROW_W = 3;
  localparam int PIN_W = NUM_ROWS + 2;
  localparam int CLK_MHZ = 200;
  localparam int HIT_PULSE_US = 2000;
  localparam int END_PULSE_US = 4000;
  localparam int DWELL_US = 200;
  localparam int MAX_CYCLE_MS = 64;
  localparam int HIT_CYCLES = HIT_PULSE_US * CLK_MHZ;
  localparam int END_CYCLES = END_PULSE_US * CLK_MHZ;
  localparam int DWELL_CYCLES = DWELL_US * CLK_MHZ;
  localparam int MAX_CYCLE_CYCLES = MAX_CYCLE_MS * 1000 * CLK_MHZ;
  localparam int GRID_SCAN_CYCLES = NUM_COLUMNS * NUM_ROWS * DWELL_CYCLES;
  // Hits that still fit the cycle bound, since each hit pauses the sweep
  localparam int MAX_HITS_IN_BUDGET = (MAX_CYCLE_CYCLES - END_CYCLES - GRID_SCAN_CYCLES) / HIT_CYCLES;
  localparam int TIMER_W = 20;
  localparam int CYCLE_CNT_W = 24;
  localparam int HIT_CNT_W = 8;
  localparam logic [COL_W-1:0] FIRST_COLUMN = 4'h0;
  localparam logic [COL_W-1:0] LAST_COLUMN = 4'hF;
  localparam logic [ROW_W-1:0] LAST_ROW = 3'h7;
  localparam logic [ROW_W-1:0] UPPER_ROW = 3'h0;
  localparam logic [COL_W-1:0] COLUMN_CODE_RST = 4'h0;
  localparam logic [ROW_W-1:0] ROW_CODE_RST = 3'h0;
  localparam logic [NUM_COLUMNS-1:0] COL_DRIVE_OFF = 16'h0000;
  localparam logic [NUM_COLUMNS-1:0] COL_DRIVE_ALL = 16'hFFFF;
  // Request pins rest high, row lines rest low
  localparam logic [PIN_W-1:0] PIN_SYNC_RST = 10'h300;

  typedef enum logic [1:0] {TSC_IDLE, TSC_SCAN, TSC_HIT, TSC_END} tsc_state_e;
endpackage

/* rtl/tsc_scanner.sv */
// Auto-scanning encoder for a 16 column by 8 row contact grid.
// Assumes row lines and request pins are asynchronous; the host samples the outputs.
`timescale 1ns/1ps
`default_nettype none
module tsc_scanner #(
  parameter int HIT_LEN = tsc_pkg::HIT_CYCLES,
  parameter int END_LEN = tsc_pkg::END_CYCLES,
  parameter int DWELL_LEN = tsc_pkg::DWELL_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic continuous_sweep_req_n,
  input wire logic standbyScanReqN,
  input wire logic [tsc_pkg::NUM_ROWS-1:0] rowSense,
  output logic [tsc_pkg::NUM_COLUMNS-1:0] columnDrive,
  output logic [tsc_pkg::COL_W-1:0] column_code,
  output logic [tsc_pkg::ROW_W-1:0] row_code,
  output logic touchHitN,
  output logic endPulse
);
  import tsc_pkg::*;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] pinS1_reg, pinS2_reg, pinS3_reg, pinFilt_reg;
  logic contReq, standbyReq, anyRow;
  logic [NUM_ROWS-1:0] rowsFilt;
  tsc_state_e state_reg, stateNext;
  logic [COL_W-1:0] colIdx_reg;
  logic [ROW_W-1:0] rowIdx_reg;
  logic cycleHit_reg;
  logic timerLoad, timerExpired, scanHit, lastPos, advance;
  logic [TIMER_W-1:0] timerValue;
  logic [COL_W-1:0] columnCode_reg;
  logic [ROW_W-1:0] rowCode_reg;
  logic touchHitN_reg, endPulse_reg;
  logic [NUM_COLUMNS-1:0] columnDrive_reg;

  function automatic logic [NUM_COLUMNS-1:0] columnSelect(input logic [COL_W-1:0] col);
    columnSelect = COL_DRIVE_OFF;
    columnSelect[col] = 1'b1;
  endfunction

  // A level change is taken only once stages two and three agree
  assign pinRaw = {continuous_sweep_req_n, standbyScanReqN, rowSense};
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pinS1_reg <= PIN_SYNC_RST;
      pinS2_reg <= PIN_SYNC_RST;
      pinS3_reg <= PIN_SYNC_RST;
      pinFilt_reg <= PIN_SYNC_RST;
    end
    else
    begin
      pinS1_reg <= pinRaw;
      pinS2_reg <= pinS1_reg;
      pinS3_reg <= pinS2_reg;
      pinFilt_reg <= (pinS2_reg & ~(pinS2_reg ^ pinS3_reg)) | (pinFilt_reg & (pinS2_reg ^ pinS3_reg));
    end
  end

  assign contReq = ~pinFilt_reg[PIN_W-1];
  assign standbyReq = ~pinFilt_reg[PIN_W-2];
  assign rowsFilt = pinFilt_reg[NUM_ROWS-1:0];
  assign anyRow = |rowsFilt;

  tsc_timer #(
    .WIDTH(TIMER_W)
  ) u_timer (
    .sys_clk(sys_clk),
    .srst(srst),
    .load(timerLoad),
    .loadValue(timerValue),
    .expired(timerExpired)
  );

  // Sweep goes left to right and bottom to top, so the last hit latched is the
  // rightmost column and, within it, the uppermost row
  assign lastPos = (colIdx_reg == LAST_COLUMN) && (rowIdx_reg == UPPER_ROW);

  always_comb
  begin
    stateNext = state_reg;
    timerLoad = 1'b0;
    timerValue = TIMER_W'(DWELL_LEN - 1);
    scanHit = 1'b0;
    case (state_reg)
      TSC_IDLE:
      begin
        if (timerExpired)
        begin
          timerLoad = 1'b1;
          if (contReq || (standbyReq && anyRow))
            stateNext = TSC_SCAN;
        end
      end
      TSC_SCAN:
      begin
        if (timerExpired)
        begin
          timerLoad = 1'b1;
          if (rowsFilt[rowIdx_reg])
          begin
            scanHit = 1'b1;
            stateNext = TSC_HIT;
            timerValue = TIMER_W'(HIT_LEN - 1);
          end
          else if (lastPos)
          begin
            stateNext = TSC_END;
            timerValue = TIMER_W'(END_LEN - 1);
          end
        end
      end
      TSC_HIT:
      begin
        if (timerExpired)
        begin
          timerLoad = 1'b1;
          if (lastPos)
          begin
            stateNext = TSC_END;
            timerValue = TIMER_W'(END_LEN - 1);
          end
          else
            stateNext = TSC_SCAN;
        end
      end
      TSC_END:
      begin
        if (timerExpired)
        begin
          timerLoad = 1'b1;
          // A standby sweep keeps going only while some key was seen
          if (contReq || (standbyReq && cycleHit_reg))
            stateNext = TSC_SCAN;
          else
            stateNext = TSC_IDLE;
        end
      end
      default:
      begin
        stateNext = TSC_IDLE;
        timerLoad = 1'b1;
      end
    endcase
  end

  assign advance = timerExpired && !lastPos && ((state_reg == TSC_SCAN && !scanHit) || state_reg == TSC_HIT);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      state_reg <= TSC_IDLE;
    else
      state_reg <= stateNext;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst || state_reg == TSC_IDLE || state_reg == TSC_END)
    begin
      colIdx_reg <= FIRST_COLUMN;
      rowIdx_reg <= LAST_ROW;
    end
    else if (advance)
    begin
      if (rowIdx_reg == UPPER_ROW)
      begin
        colIdx_reg <= colIdx_reg + 1'b1;
        rowIdx_reg <= LAST_ROW;
      end
      else
        rowIdx_reg <= rowIdx_reg - 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      cycleHit_reg <= 1'b0;
    else if (scanHit)
      cycleHit_reg <= 1'b1;
    else if (state_reg == TSC_END && timerExpired)
      cycleHit_reg <= 1'b0;
  end

  // Position is only ever overwritten by a new hit
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      columnCode_reg <= COLUMN_CODE_RST;
      rowCode_reg <= ROW_CODE_RST;
    end
    else if (scanHit)
    begin
      columnCode_reg <= colIdx_reg;
      rowCode_reg <= rowIdx_reg;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      touchHitN_reg <= 1'b1;
      endPulse_reg <= 1'b0;
    end
    else
    begin
      touchHitN_reg <= (stateNext != TSC_HIT);
      endPulse_reg <= (stateNext == TSC_END);
    end
  end

  // Column drive lags the index by one cycle, far inside the dwell time
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      columnDrive_reg <= COL_DRIVE_OFF;
    else if (state_reg == TSC_SCAN || state_reg == TSC_HIT)
      columnDrive_reg <= columnSelect(colIdx_reg);
    else if (state_reg == TSC_IDLE && standbyReq)
      columnDrive_reg <= COL_DRIVE_ALL;
    else
      columnDrive_reg <= COL_DRIVE_OFF;
  end

  assign column_code = columnCode_reg;
  assign row_code = rowCode_reg;
  assign touchHitN = touchHitN_reg;
  assign endPulse = endPulse_reg;
  assign columnDrive = columnDrive_reg;

  // Helper counters for checking long pulse and cycle lengths
  logic [TIMER_W:0] hitWidth_reg, endWidth_reg;
  logic [CYCLE_CNT_W-1:0] cycleLen_reg;
  logic [HIT_CNT_W-1:0] hitCount_reg;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      hitWidth_reg <= '0;
      endWidth_reg <= '0;
      cycleLen_reg <= '0;
      hitCount_reg <= '0;
    end
    else
    begin
      hitWidth_reg <= touchHitN_reg ? '0 : hitWidth_reg + 1'b1;
      endWidth_reg <= endPulse_reg ? endWidth_reg + 1'b1 : '0;
      cycleLen_reg <= (state_reg == TSC_IDLE || (state_reg == TSC_END && timerExpired)) ? '0 : cycleLen_reg + 1'b1;
      if (state_reg == TSC_IDLE || (state_reg == TSC_END && timerExpired))
        hitCount_reg <= '0;
      else if (scanHit && hitCount_reg != '1)
        hitCount_reg <= hitCount_reg + 1'b1;
    end
  end

  sequence hitSampled;
    state_reg == TSC_SCAN && scanHit;
  endsequence

  hit_width_a: assert property ($rose(touchHitN_reg) |-> hitWidth_reg == (TIMER_W+1)'(HIT_LEN))
    else $error("Hit pulse length wrong");
  end_width_a: assert property ($fell(endPulse_reg) |-> endWidth_reg == (TIMER_W+1)'(END_LEN))
    else $error("End pulse length wrong");
  hit_latch_a: assert property (hitSampled |=> !touchHitN_reg && column_code == $past(colIdx_reg)
    && row_code == $past(rowIdx_reg))
    else $error("Hit position not latched");
  code_hold_a: assert property (!$past(scanHit) |-> $stable(column_code) && $stable(row_code))
    else $error("Position changed without a hit");
  row_code_a: assert property (!touchHitN_reg |-> row_code == rowIdx_reg && column_code == colIdx_reg)
    else $error("Row code differs from scanned row");
  one_hit_a: assert property ($fell(touchHitN_reg) |-> $past(scanHit) && $past(rowsFilt[rowIdx_reg]))
    else $error("Hit pulse without touched position");
  scan_order_a: assert property ($rose(endPulse_reg) |-> $past(colIdx_reg) == LAST_COLUMN
    && $past(rowIdx_reg) == UPPER_ROW)
    else $error("Cycle ended before last position");
  cycle_bound_a: assert property ((state_reg == TSC_END && timerExpired
    && hitCount_reg <= HIT_CNT_W'(MAX_HITS_IN_BUDGET)) |-> cycleLen_reg < CYCLE_CNT_W'(MAX_CYCLE_CYCLES))
    else $error("Scan cycle too long");
  cont_run_a: assert property ($fell(endPulse_reg) && $past(contReq) |-> state_reg == TSC_SCAN)
    else $error("Continuous sweep stopped");
  standby_wait_a: assert property (state_reg == TSC_SCAN && $past(state_reg) == TSC_IDLE
    |-> $past(contReq) || ($past(standbyReq) && $past(anyRow)))
    else $error("Scan started without touch");
  idle_quiet_a: assert property (state_reg == TSC_IDLE |-> touchHitN_reg && !endPulse_reg)
    else $error("Pulse active while idle");
endmodule // tsc_scanner
`default_nettype wire

/* rtl/tsc_timer.sv */
// Load-and-count-down timer used for dwell and pulse lengths.
// Assumes the caller loads length minus one; expired is high at zero.
`timescale 1ns/1ps
`default_nettype none
module tsc_timer #(
  parameter int WIDTH = tsc_pkg::TIMER_W
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  output logic expired
);
  logic [WIDTH-1:0] count_reg;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      count_reg <= '0;
    else if (load)
      count_reg <= loadValue;
    else if (count_reg != '0)
      count_reg <= count_reg - 1'b1;
  end

  assign expired = (count_reg == '0);
endmodule // tsc_timer
`default_nettype wire

/* verification/touch_grid_auto_scanner_tb.sv */
// Self-checking bench for the touch grid scanner with short pulse and dwell lengths.
// Assumes tsc_pkg, tsc_scanner and tsc_grid_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module touch_grid_auto_scanner_tb;
  import tsc_pkg::*;
  localparam int HIT = 20;
  localparam int ENDL = 40;
  localparam int DWELL = 8;
  localparam int CYC = NUM_COLUMNS * NUM_ROWS * DWELL;
  logic sysClk = 1'b0;
  logic srst = 1'b1;
  logic contReqN = 1'b1;
  logic standbyReqN = 1'b1;
  logic [127:0] keyMap = 128'h0;
  logic [15:0] columnDrive;
  logic [7:0] rowSense;
  logic [3:0] colCode;
  logic [2:0] rowCode;
  logic touchHitN;
  logic endPulse;
  logic hitPrev = 1'b1;
  logic endPrev = 1'b0;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  int hits = 0;
  int ends = 0;

  tsc_scanner #(.HIT_LEN(HIT), .END_LEN(ENDL), .DWELL_LEN(DWELL)) i_dut (
    .sys_clk(sysClk), .srst(srst), .continuous_sweep_req_n(contReqN), .standbyScanReqN(standbyReqN),
    .rowSense(rowSense), .columnDrive(columnDrive), .column_code(colCode), .row_code(rowCode),
    .touchHitN(touchHitN), .endPulse(endPulse));
  tsc_grid_model i_grid (.columnDrive(columnDrive), .keyMap(keyMap), .rowSense(rowSense));

  initial
  begin
    forever #2.5 sysClk = ~sysClk;
  end

  // Edge counters see the pre-edge values, so each pulse start is counted once
  always @(posedge sysClk)
  begin
    cycles++;
    if (hitPrev === 1'b1 && touchHitN === 1'b0)
      hits++;
    if (endPrev === 1'b0 && endPulse === 1'b1)
      ends++;
    hitPrev = touchHitN;
    endPrev = endPulse;
    if (cycles == 30000)
    begin
      errors++;
      end_sim();
    end
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick();
    @(posedge sysClk);
    #1;
  endtask

  function automatic bit active(bit isEnd);
    return isEnd ? (endPulse === 1'b1) : (touchHitN === 1'b0);
  endfunction

  // Bounded wait: a missing pulse shows up in the level check that follows
  task automatic wait_pulse(bit isEnd, int limit);
    for (int i = 0; i < limit && !active(isEnd); i++)
      tick();
  endtask

  task automatic pulse_len(bit isEnd, output int n);
    n = 0;
    while (active(isEnd) && n < 1000)
    begin
      n++;
      tick();
    end
  endtask

  task automatic t_reset();
    #1;
    check("column_code", 16'(colCode), 16'h0000);
    check("row_code", 16'(rowCode), 16'h0000);
    check("touchHitN", 16'(touchHitN), 16'h0001);
    check("endPulse", 16'(endPulse), 16'h0000);
    check("columnDrive", columnDrive, 16'h0000);
    @(posedge sysClk);
    srst <= 1'b0;
    $display("Test reset done");
  endtask

  task automatic t_single();
    int n;
    int h0;
    h0 = hits;
    @(posedge sysClk);
    keyMap[10*8+3] <= 1'b1;
    contReqN <= 1'b0;
    wait_pulse(0, CYC + 100);
    check("touchHitN", 16'(touchHitN), 16'h0000);
    check("column_code", 16'(colCode), 16'h000A);
    check("row_code", 16'(rowCode), 16'h0003);
    pulse_len(0, n);
    check("hit width", 16'(n), 16'(HIT));
    @(posedge sysClk);
    keyMap <= 128'h0;
    wait_pulse(1, CYC);
    check("endPulse", 16'(endPulse), 16'h0001);
    check("hits per cycle", 16'(hits - h0), 16'h0001);
    check("held column", 16'(colCode), 16'h000A);
    check("held row", 16'(rowCode), 16'h0003);
    pulse_len(1, n);
    check("end width", 16'(n), 16'(ENDL));
    // Key released: the sweep must still run a whole cycle
    n = 0;
    while (!active(1) && n < 2 * CYC)
    begin
      n++;
      tick();
    end
    check("next end", 16'(endPulse), 16'h0001);
    check("cycle bound", 16'(n <= CYC + 8), 16'h0001);
    $display("Test single done");
  endtask

  task automatic t_multi();
    int n;
    int h0;
    pulse_len(1, n);
    h0 = hits;
    @(posedge sysClk);
    keyMap[4*8+3] <= 1'b1;
    keyMap[11*8+1] <= 1'b1;
    keyMap[11*8+5] <= 1'b1;
    wait_pulse(1, CYC + 4 * HIT + 50);
    check("endPulse", 16'(endPulse), 16'h0001);
    check("hits per cycle", 16'(hits - h0), 16'h0003);
    check("winner column", 16'(colCode), 16'h000B);
    check("winner row", 16'(rowCode), 16'h0001);
    @(posedge sysClk);
    keyMap <= 128'h0;
    contReqN <= 1'b1;
    $display("Test multi done");
  endtask

  task automatic t_standby();
    int h0;
    int e0;
    repeat (2 * CYC) tick();
    @(posedge sysClk);
    standbyReqN <= 1'b0;
    h0 = hits;
    e0 = ends;
    repeat (2 * CYC) tick();
    check("idle drive", columnDrive, 16'hFFFF);
    check("idle hits", 16'(hits - h0), 16'h0000);
    check("idle ends", 16'(ends - e0), 16'h0000);
    @(posedge sysClk);
    keyMap[2*8+7] <= 1'b1;
    wait_pulse(0, CYC + 100);
    check("touchHitN", 16'(touchHitN), 16'h0000);
    check("column_code", 16'(colCode), 16'h0002);
    check("row_code", 16'(rowCode), 16'h0007);
    @(posedge sysClk);
    keyMap <= 128'h0;
    e0 = ends;
    // One cycle with the hit, one empty cycle, then the scan must stop
    repeat (4 * CYC) tick();
    check("standby ends", 16'(ends - e0), 16'h0002);
    $display("Test standby done");
  endtask

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge sysClk);
    t_reset();
    t_single();
    t_multi();
    t_standby();
    end_sim();
  end
endmodule // touch_grid_auto_scanner_tb
`default_nettype wire

/* verification/tsc_grid_model.sv */
// Behavioural contact grid standing at the far side of the scanner.
// Assumes columns are driven active high and rows sensed active high.
`timescale 1ns/1ps
`default_nettype none
module tsc_grid_model
(
  input wire logic [15:0] columnDrive,
  input wire logic [127:0] keyMap,
  output logic [7:0] rowSense
);
  // A pressed key shorts its column line to its row line, so several columns driven at once OR together
  always_comb
  begin
    rowSense = 8'h00;
    for (int c = 0; c < 16; c++)
      rowSense |= keyMap[c*8 +: 8] & {8{columnDrive[c]}};
  end
endmodule // tsc_grid_model
`default_nettype wire
